/* ptf_timer.sv */
// Purpose: periodic timer front end with byte-buffered register access
// Assumes: fh_tick and sub_tick are one-cycle enables made on clk
// Notes: registers reached over classic Wishbone, one byte per word
//
// Operation
// - free-running up-counter compared with comparators; match interrupts
// - three-bit clock select picks system, high, sub or pin clock
// - external count pin counts on rising or falling edge per select
// - capture input triggers on rising, falling or both edges
// - separate interrupt sources for comparator A and comparator P
// - inverted output pin always complements primary output pin
// - compare match mode drives output high, low or toggles
// - PWM appears on primary pin and complement on inverted pin
// - edge aligned PWM, duty or period adjustable, not both
// - high bytes direct, low bytes only through one holding buffer
// - buffer moves to or from low byte only on high access
// - compare low write updates only the holding buffer
// - compare high write stores high byte and loads low from buffer
// - high byte read returns high and copies low into buffer
// - low byte read returns the holding buffer, not live value
// - selector bits 7-6 route pin 3: gpio, inv out, amp, vref
// - bits 5-4 route pin 2: gpio/count, analog 2, amp1 input
// - bits 3-2 route pin 1: gpio/capture, analog 0, amp0 output
// - bits 1-0 route pin 0: gpio, analog 1, timer out, amp1
// - counter and compare registers are ten bits; A and P fully compared, B never compared
// - software only clears counter via run bit rising edge
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module ptf_timer
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fh_tick,
  input wire logic sub_tick,
  input wire logic [3:0] pad_in,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  output ptf_pkg::ptf_pad_type pad,
  output logic timer_out_pin,
  output logic timer_out_inv_pin,
  output logic compare_a_irq,
  output logic compare_p_irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // high byte read value of a ten-bit pair
  function automatic logic [7:0] ptf_high(input logic [9:0] v);
    ptf_high = {6'h00, v[9:8]};
  endfunction : ptf_high

  // edge test on a filtered level: kind 00 rise, 01 fall, 10 both
  function automatic logic ptf_edge(input logic rise, input logic fall,
                                    input logic [1:0] kind);
    unique case (kind)
      ptf_pkg::IO_00: ptf_edge = rise;
      ptf_pkg::IO_01: ptf_edge = fall;
      ptf_pkg::IO_10: ptf_edge = rise | fall;
      ptf_pkg::IO_11: ptf_edge = 1'b0;
    endcase
  endfunction : ptf_edge

  ptf_pkg::ptf_state_type s;
  ptf_pkg::ptf_state_type next_s;

  logic [1:0] pin3_function_field;
  logic [1:0] pin2_function_field;
  logic [1:0] pin1_function_field;
  logic [1:0] pin0_function_field;
  logic [2:0] count_clock_select;
  logic [1:0] mode;
  logic [1:0] pin_function_field;
  logic counter_run_bit;
  logic pause;
  logic ext_count_pin;
  logic capture_in_pin;

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  assign pin3_function_field = s.pin_sel[7:6];
  assign pin2_function_field = s.pin_sel[5:4];
  assign pin1_function_field = s.pin_sel[3:2];
  assign pin0_function_field = s.pin_sel[1:0];
  assign count_clock_select = s.ctl0[ptf_pkg::CKS_HI:ptf_pkg::CKS_LO];
  assign counter_run_bit = s.ctl0[ptf_pkg::RUN_BIT];
  assign pause = s.ctl0[ptf_pkg::PAUSE_BIT];
  assign mode = s.ctl1[ptf_pkg::MODE_HI:ptf_pkg::MODE_LO];
  assign pin_function_field = s.ctl1[ptf_pkg::IO_HI:ptf_pkg::IO_LO];

  // timer inputs only see the pin while it is routed to digital use
  assign ext_count_pin = pad_in[2] &
    (pin2_function_field[1] == pin2_function_field[0]);
  assign capture_in_pin = pad_in[1] &
    (pin1_function_field[1] == pin1_function_field[0]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // all behaviour in one pass; later sections override earlier ones
  always_comb
  begin
    logic cnt_ok;
    logic cnt_rise;
    logic cnt_fall;
    logic cap_ok;
    logic cap_hit;
    logic tick;
    logic counting;
    logic run_rise;
    logic hit_a;
    logic hit_p;
    logic clr;
    logic req;
    logic wr;
    logic clr_a;
    logic clr_p;
    cnt_ok = 1'b0;
    cnt_rise = 1'b0;
    cnt_fall = 1'b0;
    cap_ok = 1'b0;
    cap_hit = 1'b0;
    tick = 1'b0;
    counting = 1'b0;
    run_rise = 1'b0;
    hit_a = 1'b0;
    hit_p = 1'b0;
    clr = 1'b0;
    req = 1'b0;
    wr = 1'b0;
    clr_a = 1'b0;
    clr_p = 1'b0;
    next_s = s;
    next_s.match_a = 1'b0;
    next_s.match_p = 1'b0;

    // three-stage synchronisers; a level counts once stages 2 and 3 agree
    next_s.cnt_sync = {s.cnt_sync[1:0], ext_count_pin};
    next_s.cap_sync = {s.cap_sync[1:0], capture_in_pin};
    cnt_ok = (s.cnt_sync[1] == s.cnt_sync[2]);
    cap_ok = (s.cap_sync[1] == s.cap_sync[2]);
    if (cnt_ok)
      next_s.cnt_lvl = s.cnt_sync[2];
    if (cap_ok)
      next_s.cap_lvl = s.cap_sync[2];
    cnt_rise = cnt_ok & s.cnt_sync[2] & ~s.cnt_lvl;
    cnt_fall = cnt_ok & ~s.cnt_sync[2] & s.cnt_lvl;
    cap_hit = ptf_edge(cap_ok & s.cap_sync[2] & ~s.cap_lvl,
                       cap_ok & ~s.cap_sync[2] & s.cap_lvl,
                       pin_function_field);

    // prescalers free-run so a clock change takes effect at once
    next_s.div4 = s.div4 + 2'h1;
    if (fh_tick)
      next_s.fh_div = s.fh_div + 6'h01;

    // counter clock choice
    unique case (count_clock_select)
      ptf_pkg::CKS_SYS4: tick = (s.div4 == ptf_pkg::DIV4_LAST);
      ptf_pkg::CKS_SYS: tick = 1'b1;
      ptf_pkg::CKS_FH16:
        tick = fh_tick & (s.fh_div[3:0] == ptf_pkg::FH16_LAST);
      ptf_pkg::CKS_FH64:
        tick = fh_tick & (s.fh_div == ptf_pkg::FH64_LAST);
      ptf_pkg::CKS_SUB_A: tick = sub_tick;
      ptf_pkg::CKS_SUB_B: tick = sub_tick;
      ptf_pkg::CKS_EXT_R: tick = cnt_rise;
      ptf_pkg::CKS_EXT_F: tick = cnt_fall;
    endcase

    // comparators look at all ten counter bits
    run_rise = counter_run_bit & ~s.run_prev;
    next_s.run_prev = counter_run_bit;
    counting = tick & counter_run_bit & ~pause;
    hit_a = counting & (s.cnt == s.cmp_a);
    hit_p = counting & (s.cnt == s.cmp_p);
    next_s.match_a = hit_a & (mode != ptf_pkg::MODE_CAP);
    next_s.match_p = hit_p;

    // clear source: P normally, A by choice; PWM period form clears on P
    if (mode == ptf_pkg::MODE_PWM)
      clr = s.ctl1[ptf_pkg::CCLR_BIT] & hit_p;
    else
      clr = s.ctl1[ptf_pkg::CCLR_BIT] ? hit_a : hit_p;

    // the run bit rising edge is software's only handle on the count
    if (run_rise)
      next_s.cnt = ptf_pkg::CNT_ZERO;
    else if (counting)
      next_s.cnt = clr ? ptf_pkg::CNT_ZERO : s.cnt + ptf_pkg::CNT_ONE;

    // output generation per operating mode
    unique case (mode)
      ptf_pkg::MODE_CMP:
      begin
        if (hit_a)
        begin
          unique case (pin_function_field)
            ptf_pkg::IO_00: next_s.out_lvl = s.out_lvl;
            ptf_pkg::IO_01: next_s.out_lvl = 1'b0;
            ptf_pkg::IO_10: next_s.out_lvl = 1'b1;
            ptf_pkg::IO_11: next_s.out_lvl = ~s.out_lvl;
          endcase
        end
      end
      ptf_pkg::MODE_PWM:
      begin
        if (hit_a)
          next_s.pulse_on = 1'b0;
        unique case (pin_function_field)
          ptf_pkg::IO_00: next_s.out_lvl = 1'b0;
          ptf_pkg::IO_01: next_s.out_lvl = 1'b1;
          ptf_pkg::IO_10:
            if (s.ctl1[ptf_pkg::CCLR_BIT])
              next_s.out_lvl = (next_s.cnt < {1'b0, s.cmp_p[9:1]});
            else
              next_s.out_lvl = (next_s.cnt < s.cmp_a);
          ptf_pkg::IO_11: next_s.out_lvl = next_s.pulse_on;
        endcase
      end
      ptf_pkg::MODE_CAP: next_s.out_lvl = s.out_lvl;
      ptf_pkg::MODE_TMR: next_s.out_lvl = s.out_lvl;
    endcase

    // starting the counter restores the programmed initial output
    if (run_rise)
    begin
      next_s.out_lvl = s.ctl1[ptf_pkg::INIT_BIT];
      next_s.pulse_on = 1'b1;
    end
    next_s.pin_lvl = next_s.out_lvl ^ s.ctl1[ptf_pkg::POL_BIT];

    // bus: one wait state, so every access costs two cycles
    req = wb_cyc_i & wb_stb_i & ~s.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    next_s.ack = req;
    if (req)
      next_s.rdata = ptf_pkg::RST_BYTE;
    if (req & ~wb_we_i)
    begin
      unique case (wb_adr_i)
        ptf_pkg::ADR_CTL0: next_s.rdata = s.ctl0;
        ptf_pkg::ADR_CTL1: next_s.rdata = s.ctl1;
        ptf_pkg::ADR_CTL2: next_s.rdata = s.ctl2;
        ptf_pkg::ADR_PIN_SEL: next_s.rdata = s.pin_sel;
        ptf_pkg::ADR_STATUS:
        begin
          next_s.rdata[ptf_pkg::FLAG_A_BIT] = s.flag_a;
          next_s.rdata[ptf_pkg::FLAG_P_BIT] = s.flag_p;
          next_s.rdata[ptf_pkg::PIN_BIT] = s.pin_lvl;
        end
        ptf_pkg::ADR_CNT_HI:
        begin
          next_s.rdata = ptf_high(s.cnt);
          next_s.hold = s.cnt[7:0];
        end
        ptf_pkg::ADR_CMPA_HI:
        begin
          next_s.rdata = ptf_high(s.cmp_a);
          next_s.hold = s.cmp_a[7:0];
        end
        ptf_pkg::ADR_CMPB_HI:
        begin
          next_s.rdata = ptf_high(s.cmp_b);
          next_s.hold = s.cmp_b[7:0];
        end
        ptf_pkg::ADR_CMPP_HI:
        begin
          next_s.rdata = ptf_high(s.cmp_p);
          next_s.hold = s.cmp_p[7:0];
        end
        ptf_pkg::ADR_CNT_LO,
        ptf_pkg::ADR_CMPA_LO,
        ptf_pkg::ADR_CMPB_LO,
        ptf_pkg::ADR_CMPP_LO: next_s.rdata = s.hold;
        default: next_s.rdata = ptf_pkg::RST_BYTE;
      endcase
    end
    if (wr)
    begin
      unique case (wb_adr_i)
        ptf_pkg::ADR_CTL0: next_s.ctl0 = {wb_dat_i[7:3], 3'h0};
        ptf_pkg::ADR_CTL1: next_s.ctl1 = wb_dat_i[7:0];
        ptf_pkg::ADR_CTL2: next_s.ctl2 = {5'h00, wb_dat_i[2:0]};
        ptf_pkg::ADR_PIN_SEL: next_s.pin_sel = wb_dat_i[7:0];
        ptf_pkg::ADR_STATUS:
        begin
          clr_a = wb_dat_i[ptf_pkg::FLAG_A_BIT];
          clr_p = wb_dat_i[ptf_pkg::FLAG_P_BIT];
        end
        ptf_pkg::ADR_CMPA_LO,
        ptf_pkg::ADR_CMPB_LO,
        ptf_pkg::ADR_CMPP_LO: next_s.hold = wb_dat_i[7:0];
        ptf_pkg::ADR_CMPA_HI:
          next_s.cmp_a = {wb_dat_i[1:0], s.hold};
        ptf_pkg::ADR_CMPB_HI:
          next_s.cmp_b = {wb_dat_i[1:0], s.hold};
        ptf_pkg::ADR_CMPP_HI:
          next_s.cmp_p = {wb_dat_i[1:0], s.hold};
        default: next_s.hold = next_s.hold;
      endcase
    end

    // a capture edge overrides a same-cycle software write of A
    if (cap_hit & (mode == ptf_pkg::MODE_CAP) & counter_run_bit)
    begin
      next_s.cmp_a = s.cnt;
      next_s.match_a = 1'b1;
    end

    // sticky flags: a new match beats a same-cycle clear
    next_s.flag_a = (s.flag_a & ~clr_a) | next_s.match_a;
    next_s.flag_p = (s.flag_p & ~clr_p) | next_s.match_p;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // every field resets to zero, matching the power-on register values
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs and pin routing
  // ----------------------------------------------------------------
  assign wb_dat_o = {24'h000000, s.rdata};
  assign wb_ack_o = s.ack;
  assign compare_a_irq = s.match_a;
  assign compare_p_irq = s.match_p;
  assign timer_out_pin = s.pin_lvl;
  assign timer_out_inv_pin = ~s.pin_lvl;

  // analog picks float the digital driver; amp and reference own the pad
  always_comb
  begin
    pad.out = gpio_out;
    pad.oe = gpio_oe;
    pad.analog = 4'h0;
    unique case (pin3_function_field)
      ptf_pkg::IO_00: pad.analog[3] = 1'b0;
      ptf_pkg::IO_01:
      begin
        pad.out[3] = ~s.pin_lvl;
        pad.oe[3] = 1'b1;
      end
      ptf_pkg::IO_10,
      ptf_pkg::IO_11:
      begin
        pad.oe[3] = 1'b0;
        pad.analog[3] = 1'b1;
      end
    endcase
    if (pin2_function_field[1] != pin2_function_field[0])
    begin
      pad.oe[2] = 1'b0;
      pad.analog[2] = 1'b1;
    end
    if (pin1_function_field[1] != pin1_function_field[0])
    begin
      pad.oe[1] = 1'b0;
      pad.analog[1] = 1'b1;
    end
    unique case (pin0_function_field)
      ptf_pkg::IO_00: pad.analog[0] = 1'b0;
      ptf_pkg::IO_10:
      begin
        pad.out[0] = s.pin_lvl;
        pad.oe[0] = 1'b1;
      end
      ptf_pkg::IO_01,
      ptf_pkg::IO_11:
      begin
        pad.oe[0] = 1'b0;
        pad.analog[0] = 1'b1;
      end
    endcase
  end

endmodule : ptf_timer

`default_nettype wire

/* ptf_pkg.sv */
// Purpose: shared constants and types of the periodic timer front end
// Assumes: classic Wishbone slave, 32-bit data, 8-bit registers
// Notes: every register sits in the low byte of its own aligned word
package ptf_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] ADR_CTL0 = 6'h00;
  localparam logic [5:0] ADR_CTL1 = 6'h04;
  localparam logic [5:0] ADR_CTL2 = 6'h08;
  localparam logic [5:0] ADR_CNT_LO = 6'h0C;
  localparam logic [5:0] ADR_CNT_HI = 6'h10;
  localparam logic [5:0] ADR_CMPA_LO = 6'h14;
  localparam logic [5:0] ADR_CMPA_HI = 6'h18;
  localparam logic [5:0] ADR_CMPB_LO = 6'h1C;
  localparam logic [5:0] ADR_CMPB_HI = 6'h20;
  localparam logic [5:0] ADR_CMPP_LO = 6'h24;
  localparam logic [5:0] ADR_CMPP_HI = 6'h28;
  localparam logic [5:0] ADR_PIN_SEL = 6'h2C;
  localparam logic [5:0] ADR_STATUS = 6'h30;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int PAUSE_BIT = 7;
  localparam int CKS_HI = 6;
  localparam int CKS_LO = 4;
  localparam int RUN_BIT = 3;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int IO_HI = 5;
  localparam int IO_LO = 4;
  localparam int INIT_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int CCLR_BIT = 0;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam int PIN_BIT = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_ONE = 10'h001;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [3:0] FH16_LAST = 4'hF;
  localparam logic [5:0] FH64_LAST = 6'h3F;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] IO_00 = 2'h0;
  localparam logic [1:0] IO_01 = 2'h1;
  localparam logic [1:0] IO_10 = 2'h2;
  localparam logic [1:0] IO_11 = 2'h3;
  localparam logic [2:0] CKS_SYS4 = 3'h0;
  localparam logic [2:0] CKS_SYS = 3'h1;
  localparam logic [2:0] CKS_FH16 = 3'h2;
  localparam logic [2:0] CKS_FH64 = 3'h3;
  localparam logic [2:0] CKS_SUB_A = 3'h4;
  localparam logic [2:0] CKS_SUB_B = 3'h5;
  localparam logic [2:0] CKS_EXT_R = 3'h6;
  localparam logic [2:0] CKS_EXT_F = 3'h7;

  // pad group: level driven and enable of each port A pin
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] analog;
  } ptf_pad_type;

  // whole state of the timer front end
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] pin_sel;
    logic [9:0] cnt;
    logic [9:0] cmp_a;
    logic [9:0] cmp_b;
    logic [9:0] cmp_p;
    logic [7:0] hold;
    logic run_prev;
    logic [2:0] cnt_sync;
    logic [2:0] cap_sync;
    logic cnt_lvl;
    logic cap_lvl;
    logic [1:0] div4;
    logic [5:0] fh_div;
    logic out_lvl;
    logic pin_lvl;
    logic pulse_on;
    logic flag_a;
    logic flag_p;
    logic match_a;
    logic match_p;
    logic ack;
    logic [7:0] rdata;
  } ptf_state_type;

endpackage : ptf_pkg

/* ptf_timer_properties.sv */
// Purpose: concurrent checks on the timer front end ports
// Assumes: one clock domain, rst_n active low
// Notes: pin checks hold whatever the selector routes
`timescale 1ns/10ps
`default_nettype none
module ptf_timer_properties
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire ptf_pkg::ptf_pad_type pad,
  input wire logic timer_out_pin,
  input wire logic timer_out_inv_pin,
  input wire logic compare_a_irq,
  input wire logic compare_p_irq
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic hi_rd;
  // high byte reads of counter or compare registers carry only bits 9:8
  assign hi_rd = !wb_we_i && (wb_adr_i == ptf_pkg::ADR_CNT_HI ||
    wb_adr_i == ptf_pkg::ADR_CMPA_HI || wb_adr_i == ptf_pkg::ADR_CMPB_HI ||
    wb_adr_i == ptf_pkg::ADR_CMPP_HI);
  property p_inv;
    timer_out_inv_pin == !timer_out_pin;
  endproperty
  a_inv: assert property (p_inv) else $error("inverted pin not complement");
  property p_ack_once;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not one pulse");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
  property p_dat_wide;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_dat_wide: assert property (p_dat_wide) else $error("upper data set");
  property p_hi_byte;
    wb_ack_o && hi_rd |-> wb_dat_o[31:2] == 30'h00000000;
  endproperty
  a_hi_byte: assert property (p_hi_byte) else $error("high byte too wide");
  property p_an_oe;
    pad.analog != 4'h0 |-> (pad.analog & pad.oe) == 4'h0;
  endproperty
  a_an_oe: assert property (p_an_oe) else $error("analog pin driven");
  property p_pin0;
    !pad.analog[0] && pad.oe[0] && pad.out[0] != gpio_out[0]
      |-> pad.out[0] == timer_out_pin;
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin0 wrong source");
  property p_pin3;
    !pad.analog[3] && pad.oe[3] && pad.out[3] != gpio_out[3]
      |-> pad.out[3] == timer_out_inv_pin;
  endproperty
  a_pin3: assert property (p_pin3) else $error("pin3 wrong source");
  property p_pin2;
    !pad.analog[2] |-> pad.out[2] == gpio_out[2] && pad.oe[2] == gpio_oe[2];
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin2 not gpio");
  property p_pin1;
    !pad.analog[1] |-> pad.out[1] == gpio_out[1] && pad.oe[1] == gpio_oe[1];
  endproperty
  a_pin1: assert property (p_pin1) else $error("pin1 not gpio");
  c_irq_a: cover property (compare_a_irq);
  c_irq_p: cover property (compare_p_irq);
  c_analog: cover property (pad.analog[0] ##1 !pad.analog[0]);
endmodule : ptf_timer_properties
bind ptf_timer ptf_timer_properties ptf_timer_properties_i (.clk(clk),
  .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pad(pad),
  .timer_out_pin(timer_out_pin), .timer_out_inv_pin(timer_out_inv_pin),
  .compare_a_irq(compare_a_irq), .compare_p_irq(compare_p_irq));
`default_nettype wire

/* ptf_pins.sv */
// Purpose: pin circuitry outside port A
// Assumes: pins 0 and 3 pulled up, pins 1 and 2 fed by bench sources
// Notes: a pin the block enables shows the block's level
`timescale 1ns/10ps
`default_nettype none
module ptf_pins
(
  input wire ptf_pkg::ptf_pad_type pad,
  input wire logic cnt_lvl,
  input wire logic cap_lvl,
  output logic [3:0] pad_in
);
  logic [3:0] src;
  // undriven pins fall back to pull-up or the outside source
  assign src = {1'b1, cnt_lvl, cap_lvl, 1'b1};
  // an enabled block driver wins over the outside source
  assign pad_in = (pad.oe & pad.out) | (~pad.oe & src);
endmodule : ptf_pins
`default_nettype wire

/* ptf_timer_bench.sv */
// Purpose: self-checking bench of the timer front end
// Assumes: classic Wishbone, one byte per word
// Notes: tick inputs pulse every other cycle so fH and fSUB share a rate
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module ptf_timer_bench;
  logic clk = 0, rst_n = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, tick = 0;
  logic [5:0] wb_adr = 6'h00;
  logic [31:0] wb_dat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, tout, tinv, irq_a, irq_p, prev_out = 0;
  logic cnt_lvl = 0, cap_lvl = 0;
  logic [3:0] pad_in, gpio_out = 4'h6, gpio_oe = 4'h9;
  ptf_pkg::ptf_pad_type pad;
  int bad_count = 0, n_tests = 0, na = 0, np = 0, nt = 0, cyc_n = 0;
  logic [7:0] q;
  ptf_timer ptf_timer_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'h1), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fh_tick(tick), .sub_tick(tick), .pad_in(pad_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pad(pad),
    .timer_out_pin(tout), .timer_out_inv_pin(tinv),
    .compare_a_irq(irq_a), .compare_p_irq(irq_p));
  ptf_pins ptf_pins_i (.pad(pad), .cnt_lvl(cnt_lvl), .cap_lvl(cap_lvl),
    .pad_in(pad_in));
  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // sources, event counters and watchdog
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    tick <= ~tick;
    if (cyc_n % 4 == 3) cnt_lvl <= ~cnt_lvl; // edges every 4 cycles
    if (irq_a === 1'b1) na <= na + 1;
    if (irq_p === 1'b1) np <= np + 1;
    if (tout !== prev_out) nt <= nt + 1;
    prev_out <= tout;
    if (cyc_n == 40000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [7:0] d, output logic [7:0] r);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= {24'h000000, d};
    @(posedge clk);
    // no local limit: a stalled slave is caught by the cycle watchdog
    while (wb_ack_o !== 1'b1)
      @(posedge clk);
    r = wb_dat_o[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    `CHK("read", e, r)
  endtask : rd
  task automatic t_pins;
    logic [3:0] an, tm, oe;
    rd(ptf_pkg::ADR_PIN_SEL, 8'h00);
    rd(6'h3C, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      an = 16'h9E70 >> (c * 4);
      tm = 16'h0180 >> (c * 4);
      oe = tm | (gpio_oe & ~an & ~tm);
      wr(ptf_pkg::ADR_PIN_SEL, 8'h55 * c);
      rd(ptf_pkg::ADR_PIN_SEL, 8'h55 * c);
      `CHK("analog", an, pad.analog)
      `CHK("oe", oe, pad.oe)
      `CHK("out", ((gpio_out & ~tm) | (4'h8 & tm)) & ~an, pad.out & ~an)
    end
    $display("test pins done");
  endtask : t_pins
  task automatic t_buffer;
    wr(ptf_pkg::ADR_CMPA_LO, 8'h34);
    rd(ptf_pkg::ADR_CMPA_HI, 8'h00);
    rd(ptf_pkg::ADR_CMPA_LO, 8'h00);
    wr(ptf_pkg::ADR_CMPA_LO, 8'h34);
    wr(ptf_pkg::ADR_CMPA_HI, 8'h02);
    rd(ptf_pkg::ADR_CMPA_HI, 8'h02);
    rd(ptf_pkg::ADR_CMPA_LO, 8'h34);
    wr(ptf_pkg::ADR_CMPP_LO, 8'h56);
    wr(ptf_pkg::ADR_CMPP_HI, 8'h01);
    rd(ptf_pkg::ADR_CMPA_LO, 8'h56);
    rd(ptf_pkg::ADR_CMPP_HI, 8'h01);
    rd(ptf_pkg::ADR_CMPP_LO, 8'h56);
    wr(ptf_pkg::ADR_CMPB_LO, 8'h78);
    wr(ptf_pkg::ADR_CMPB_HI, 8'h03);
    rd(ptf_pkg::ADR_CMPB_HI, 8'h03);
    rd(ptf_pkg::ADR_CMPB_LO, 8'h78);
    $display("test buffer done");
  endtask : t_buffer
  task automatic t_counter;
    logic [7:0] h, l;
    wr(ptf_pkg::ADR_CTL0, 8'h18);
    repeat (20) @(posedge clk);
    wr(ptf_pkg::ADR_CTL0, 8'h98);
    bus(1'b0, ptf_pkg::ADR_CNT_HI, 8'h00, h);
    bus(1'b0, ptf_pkg::ADR_CNT_LO, 8'h00, l);
    `CHK("counted", 1'b1, l != 8'h00)
    wr(ptf_pkg::ADR_CNT_LO, 8'h55);
    wr(ptf_pkg::ADR_CNT_HI, 8'h01);
    rd(ptf_pkg::ADR_CNT_HI, h);
    rd(ptf_pkg::ADR_CNT_LO, l);
    wr(ptf_pkg::ADR_CTL0, 8'h10);
    wr(ptf_pkg::ADR_CTL0, 8'h98);
    rd(ptf_pkg::ADR_CNT_HI, 8'h00);
    rd(ptf_pkg::ADR_CNT_LO, 8'h00);
    $display("test counter done");
  endtask : t_counter
  task automatic t_rate;
    int per [8] = '{40, 10, 320, 1280, 20, 20, 80, 80};
    int sa, sp, st;
    wr(ptf_pkg::ADR_PIN_SEL, 8'h42);
    wr(ptf_pkg::ADR_CMPP_LO, 8'h09);
    wr(ptf_pkg::ADR_CMPP_HI, 8'h00);
    wr(ptf_pkg::ADR_CMPA_LO, 8'h04);
    wr(ptf_pkg::ADR_CMPA_HI, 8'h00);
    wr(ptf_pkg::ADR_CTL1, 8'h30);
    for (int k = 0; k < 8; k++)
    begin
      wr(ptf_pkg::ADR_CTL0, 8'h00);
      wr(ptf_pkg::ADR_CTL0, {1'b0, 3'(k), 4'h8});
      while (irq_p !== 1'b1)
        @(posedge clk);
      sa = na;
      sp = np;
      st = nt;
      repeat (10 * per[k]) @(posedge clk);
      `CHK("p irqs", 10, np - sp)
      `CHK("a irqs", 10, na - sa)
      `CHK("toggles", 10, nt - st)
    end
    $display("test rate done");
  endtask : t_rate
  task automatic t_level;
    logic [7:0] v [3] = '{8'h10, 8'h20, 8'h24};
    logic e [3] = '{1'b0, 1'b1, 1'b0};
    wr(ptf_pkg::ADR_CTL0, 8'h00);
    wr(ptf_pkg::ADR_CTL0, 8'h18);
    for (int k = 0; k < 3; k++)
    begin
      wr(ptf_pkg::ADR_CTL1, v[k]);
      repeat (25) @(posedge clk);
      `CHK("level", e[k], tout)
      `CHK("pin0", e[k], pad.out[0])
      `CHK("pin3", !e[k], pad.out[3])
    end
    $display("test level done");
  endtask : t_level
  task automatic t_pwm;
    int st;
    wr(ptf_pkg::ADR_CTL1, 8'hA1);
    for (int k = 0; k < 2; k++)
    begin
      wr(ptf_pkg::ADR_CMPP_LO, k ? 8'h13 : 8'h09);
      wr(ptf_pkg::ADR_CMPP_HI, 8'h00);
      repeat (40) @(posedge clk);
      st = nt;
      repeat (200) @(posedge clk);
      `CHK("pwm edges", k ? 20 : 40, nt - st)
    end
    $display("test pwm done");
  endtask : t_pwm
  task automatic t_capture;
    int e [4] = '{1, 1, 2, 0};
    int sa;
    for (int f = 0; f < 4; f++)
    begin
      wr(ptf_pkg::ADR_CTL0, 8'h00);
      wr(ptf_pkg::ADR_CTL1, {2'h1, 2'(f), 4'h0});
      wr(ptf_pkg::ADR_CTL0, 8'h88);
      sa = na;
      cap_lvl <= 1'b1;
      repeat (12) @(posedge clk);
      cap_lvl <= 1'b0;
      repeat (12) @(posedge clk);
      `CHK("captures", e[f], na - sa)
    end
    rd(ptf_pkg::ADR_CMPA_HI, 8'h00);
    rd(ptf_pkg::ADR_CMPA_LO, 8'h00);
    rd(ptf_pkg::ADR_STATUS, 8'h03);
    wr(ptf_pkg::ADR_STATUS, 8'h03);
    rd(ptf_pkg::ADR_STATUS, 8'h00);
    $display("test capture done");
  endtask : t_capture
  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("inv reset", 1'b1, tinv)
    t_pins();
    t_buffer();
    t_counter();
    t_rate();
    t_level();
    t_pwm();
    t_capture();
    test_done();
  end
endmodule : ptf_timer_bench
`default_nettype wire
